// ===== hw/gpm_consts.svh
// register indexes, field codes and reset values of the seven-pin port
// Contract
// - output gpio pin drives its data bit
// - output pins read back written data
// - input pins read back sampled level
// - direction 0 output, 1 input; reset output
// - output drive: hiz, pch od, nch od, cmos
// - input mode selects hiz, pull-down or pull-up
// - input codes 00 hiz, 01 down, 10 up, 11 hiz
// - drive configuration resets to 00 everywhere
// - function 00 is gpio, reset value
// - pin 6 code 01 gives low-speed clock
// - pin 5 code 10 gives pwm five
// - pin 4 code 10 gives pwm four
// - pins 0 to 3 allow code 00 only
// - prohibited output: hiz/pch hiz, nch/cmos low
// - drive config bytes pair as 16-bit word
// - function select bytes pair as 16-bit word
// - pin 0 level feeds pwm event input
`ifndef GPM_CONSTS_SVH
`define GPM_CONSTS_SVH
`define GPM_PINS         7
`define GPM_ADR_W        18
`define GPM_IDX_DATA     16'hf218
`define GPM_IDX_DIR      16'hf219
`define GPM_IDX_CFG_LO   16'hf21a
`define GPM_IDX_CFG_HI   16'hf21b
`define GPM_IDX_FSEL_LO  16'hf21c
`define GPM_IDX_FSEL_HI  16'hf21d
`define GPM_RST_BYTE     8'h00
`define GPM_FS_GPIO      2'b00
`define GPM_FS_LOW_SPEED_CLOCK     2'b01
`define GPM_FS_PWM       2'b10
`define GPM_CFG_HIZ      2'b00
`define GPM_CFG_POD      2'b01
`define GPM_CFG_NOD      2'b10
`define GPM_CFG_CMOS     2'b11
`define GPM_IN_PD        2'b01
`define GPM_IN_PU        2'b10
`define GPM_PIN_EVT      0
`define GPM_PIN_PWM_CHANNEL_FOUR     4
`define GPM_PIN_PWM_CHANNEL_FIVE     5
`define GPM_PIN_LOW_SPEED_CLOCK    6
`endif

// ===== hw/gpm_pkg.sv
// state type of the seven-pin port
`include "gpm_consts.svh"
package gpm_pkg;
    typedef struct packed {
        logic [`GPM_PINS-1:0] data;
        logic [`GPM_PINS-1:0] dir;
        logic [7:0]           cfg_lo;
        logic [7:0]           cfg_hi;
        logic [7:0]           fsel_lo;
        logic [7:0]           fsel_hi;
        logic [`GPM_PINS-1:0] sync1;
        logic [`GPM_PINS-1:0] sync2;
        logic                 ack;
        logic [31:0]          rdata;
        logic [`GPM_PINS-1:0] pin;
        logic [`GPM_PINS-1:0] oe;
        logic [`GPM_PINS-1:0] pu;
        logic [`GPM_PINS-1:0] pd;
        logic                 evt;
    } gpm_state_t;
endpackage

// ===== hw/gpm_port.sv
// seven-pin gpio port with function mux and wishbone register slave
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "gpm_consts.svh"
module gpm_port
    import gpm_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [`GPM_ADR_W-1:0] adr_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [31:0]           dat_i,
    output logic      [31:0]           dat_o,
    output logic                       ack_o,
    input  wire logic [`GPM_PINS-1:0]  pin_i,
    output logic      [`GPM_PINS-1:0]  pin_o,
    output logic      [`GPM_PINS-1:0]  pin_oe_o,
    output logic      [`GPM_PINS-1:0]  pull_up_o,
    output logic      [`GPM_PINS-1:0]  pull_down_o,
    input  wire logic                  low_speed_clock_i,
    input  wire logic                  pwm_channel_four_i,
    input  wire logic                  pwm_channel_five_i,
    output logic                       pwm_external_event_input_o
);
    gpm_state_t st;
    gpm_state_t next_st;
    logic [1:0] fs;
    logic [1:0] cf;
    logic       src_ok;
    logic       src_v;
    logic       req;
    logic [15:0] idx;

    assign req = cyc_i && stb_i && !st.ack;
    assign idx = adr_i[`GPM_ADR_W-1:2];

    always_comb
    begin
        next_st = st;
        fs = 2'b00;
        cf = 2'b00;
        src_ok = 1'b0;
        src_v = 1'b0;
        // two-stage sync; only the second stage is read by logic
        next_st.sync1 = pin_i;
        next_st.sync2 = st.sync1;
        next_st.evt = st.sync2[`GPM_PIN_EVT];
        next_st.ack = 1'b0;
        if (req)
        begin
            // unmapped offsets still ack with zero data so the bus never hangs
            next_st.ack = 1'b1;
            next_st.rdata = 32'h0000_0000;
            case (idx)
                `GPM_IDX_DATA:
                begin
                    // input pins show the pin, output pins the latch
                    next_st.rdata[`GPM_PINS-1:0] = (st.data & ~st.dir) | (st.sync2 & st.dir);
                    if (we_i && sel_i[0])
                        next_st.data = dat_i[`GPM_PINS-1:0];
                end
                `GPM_IDX_DIR:
                begin
                    next_st.rdata[`GPM_PINS-1:0] = st.dir;
                    if (we_i && sel_i[0])
                        next_st.dir = dat_i[`GPM_PINS-1:0];
                end
                `GPM_IDX_CFG_LO:
                begin
                    next_st.rdata[15:0] = {st.cfg_hi, st.cfg_lo};
                    if (we_i && sel_i[0])
                        next_st.cfg_lo = dat_i[7:0];
                    if (we_i && sel_i[1])
                        next_st.cfg_hi = dat_i[15:8];
                end
                `GPM_IDX_CFG_HI:
                begin
                    next_st.rdata[7:0] = st.cfg_hi;
                    if (we_i && sel_i[0])
                        next_st.cfg_hi = dat_i[7:0];
                end
                `GPM_IDX_FSEL_LO:
                begin
                    next_st.rdata[15:0] = {st.fsel_hi, st.fsel_lo};
                    if (we_i && sel_i[0])
                        next_st.fsel_lo = dat_i[7:0];
                    if (we_i && sel_i[1])
                        next_st.fsel_hi = dat_i[15:8];
                end
                `GPM_IDX_FSEL_HI:
                begin
                    next_st.rdata[7:0] = st.fsel_hi;
                    if (we_i && sel_i[0])
                        next_st.fsel_hi = dat_i[7:0];
                end
                default:
                    next_st.rdata = 32'h0000_0000;
            endcase
        end
        // pin drivers are computed from the registered state, so a write
        // reaches the pin one cycle after the register takes it
        for (int i = 0; i < `GPM_PINS; i++)
        begin
            fs = {st.fsel_hi[i], st.fsel_lo[i]};
            cf = {st.cfg_hi[i], st.cfg_lo[i]};
            src_ok = 1'b0;
            src_v = 1'b0;
            if (fs == `GPM_FS_GPIO)
            begin
                src_ok = 1'b1;
                src_v = st.data[i];
            end
            else if (i == `GPM_PIN_LOW_SPEED_CLOCK && fs == `GPM_FS_LOW_SPEED_CLOCK)
            begin
                src_ok = 1'b1;
                src_v = low_speed_clock_i;
            end
            else if (i == `GPM_PIN_PWM_CHANNEL_FIVE && fs == `GPM_FS_PWM)
            begin
                src_ok = 1'b1;
                src_v = pwm_channel_five_i;
            end
            else if (i == `GPM_PIN_PWM_CHANNEL_FOUR && fs == `GPM_FS_PWM)
            begin
                src_ok = 1'b1;
                src_v = pwm_channel_four_i;
            end
            // every other code, including all non-zero codes on pins 0..3
            next_st.pin[i] = 1'b0;
            next_st.oe[i] = 1'b0;
            next_st.pu[i] = 1'b0;
            next_st.pd[i] = 1'b0;
            if (st.dir[i])
            begin
                // input: never driven, codes 00 and 11 are plain hiz
                next_st.pd[i] = (cf == `GPM_IN_PD);
                next_st.pu[i] = (cf == `GPM_IN_PU);
            end
            else if (!src_ok)
            begin
                next_st.oe[i] = cf[1];
            end
            else
            begin
                case (cf)
                    `GPM_CFG_POD:
                    begin
                        next_st.oe[i] = src_v;
                        next_st.pin[i] = 1'b1;
                    end
                    `GPM_CFG_NOD:
                        next_st.oe[i] = !src_v;
                    `GPM_CFG_CMOS:
                    begin
                        next_st.oe[i] = 1'b1;
                        next_st.pin[i] = src_v;
                    end
                    default:
                        next_st.oe[i] = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
            st.data <= `GPM_PINS'(`GPM_RST_BYTE);
            st.dir <= `GPM_PINS'(`GPM_RST_BYTE);
            st.cfg_lo <= `GPM_RST_BYTE;
            st.cfg_hi <= `GPM_RST_BYTE;
            st.fsel_lo <= `GPM_RST_BYTE;
            st.fsel_hi <= `GPM_RST_BYTE;
        end
        else
            st <= next_st;
    end

    assign dat_o = st.rdata;
    assign ack_o = st.ack;
    assign pin_o = st.pin;
    assign pin_oe_o = st.oe;
    assign pull_up_o = st.pu;
    assign pull_down_o = st.pd;
    assign pwm_external_event_input_o = st.evt;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence rd_data_s;
        req && !we_i && idx == `GPM_IDX_DATA;
    endsequence

    sequence rd_any_s;
        req && !we_i;
    endsequence

    sequence wr_any_s;
        req && we_i;
    endsequence

    // anything outside the six register indexes
    sequence unmapped_s;
        req && (idx < `GPM_IDX_DATA || idx > `GPM_IDX_FSEL_HI);
    endsequence

    bus_ack_pulse_a: assert property (req |=> ack_o ##1 !ack_o)
        else $error("ack not a single cycle after request");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    cmos_drive_a: assert property (
        !st.dir[0] && st.fsel_lo[0] == 1'b0 && st.fsel_hi[0] == 1'b0 && st.cfg_lo[0] && st.cfg_hi[0]
        |=> pin_oe_o[0] && pin_o[0] == $past(st.data[0]))
        else $error("cmos gpio pin not driving data");
    data_readback_a: assert property (rd_data_s ##0 !st.dir[1]
        |=> dat_o[1] == $past(st.data[1]) && dat_o[7] == 1'b0)
        else $error("output pin readback wrong");
    input_read_a: assert property (rd_data_s ##0 st.dir[2]
        |=> dat_o[2] == $past(st.sync2[2]))
        else $error("input pin read not the sampled level");
    input_undriven_a: assert property (st.dir[3] |=> !pin_oe_o[3])
        else $error("input pin driven");
    pull_select_a: assert property (st.dir[5] && {st.cfg_hi[5], st.cfg_lo[5]} == `GPM_IN_PU
        |=> pull_up_o[5] && !pull_down_o[5])
        else $error("pull-up not applied");
    prohibited_low_a: assert property (!st.dir[0] && st.fsel_lo[0] && st.cfg_hi[0]
        |=> pin_oe_o[0] && !pin_o[0])
        else $error("prohibited code not held low");
    // the chain restarts at zero on reset, so only judge it three clean edges later
    event_follow_a: assert property (!$past(rst_i, 1) && !$past(rst_i, 2) && !$past(rst_i, 3)
        |-> pwm_external_event_input_o == $past(pin_i[0], 3))
        else $error("event input not tracking pin 0");
    reset_state_a: assert property ($rose(!rst_i) |-> st.dir == '0 && pin_oe_o == '0)
        else $error("port not hiz output after reset");
    low_speed_clock_route_a: assert property (!st.dir[6] && st.cfg_lo[6] && st.cfg_hi[6]
        && !st.fsel_hi[6] && st.fsel_lo[6] |=> pin_o[6] == $past(low_speed_clock_i))
        else $error("low-speed clock not on pin 6");

    read_upper_zero_a: assert property (rd_any_s
        |=> dat_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");

    unmapped_read_a: assert property (unmapped_s
        |=> dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    unmapped_write_a: assert property (unmapped_s ##0 wr_any_s
        |=> $stable(st.data) && $stable(st.dir) && $stable(st.cfg_lo) && $stable(st.fsel_lo))
        else $error("unmapped write changed a register");

    dir_read_a: assert property (rd_any_s ##0 idx == `GPM_IDX_DIR
        |=> dat_o == {25'h0, $past(st.dir)})
        else $error("direction read wrong");

    cfg_word_read_a: assert property (rd_any_s ##0 idx == `GPM_IDX_CFG_LO
        |=> dat_o[15:0] == {$past(st.cfg_hi), $past(st.cfg_lo)})
        else $error("config word read wrong");

    cfg_hi_read_a: assert property (rd_any_s ##0 idx == `GPM_IDX_CFG_HI
        |=> dat_o[15:0] == {8'h00, $past(st.cfg_hi)})
        else $error("config high read wrong");

    fsel_word_read_a: assert property (rd_any_s ##0 idx == `GPM_IDX_FSEL_LO
        |=> dat_o[15:0] == {$past(st.fsel_hi), $past(st.fsel_lo)})
        else $error("function word read wrong");

    fsel_hi_read_a: assert property (rd_any_s ##0 idx == `GPM_IDX_FSEL_HI
        |=> dat_o[15:0] == {8'h00, $past(st.fsel_hi)})
        else $error("function high read wrong");

    data_write_a: assert property (wr_any_s ##0 sel_i[0] && idx == `GPM_IDX_DATA
        |=> st.data == $past(dat_i[6:0]))
        else $error("data write lost");

    dir_write_a: assert property (wr_any_s ##0 sel_i[0] && idx == `GPM_IDX_DIR
        |=> st.dir == $past(dat_i[6:0]))
        else $error("direction write lost");

    cfg_lo_write_a: assert property (wr_any_s ##0 sel_i[0] && idx == `GPM_IDX_CFG_LO
        |=> st.cfg_lo == $past(dat_i[7:0]))
        else $error("config low write lost");

    cfg_pair_write_a: assert property (wr_any_s ##0 sel_i[1] && idx == `GPM_IDX_CFG_LO
        |=> st.cfg_hi == $past(dat_i[15:8]))
        else $error("config high via word lost");

    cfg_hi_write_a: assert property (wr_any_s ##0 sel_i[0] && idx == `GPM_IDX_CFG_HI
        |=> st.cfg_hi == $past(dat_i[7:0]))
        else $error("config high write lost");

    fsel_lo_write_a: assert property (wr_any_s ##0 sel_i[0] && idx == `GPM_IDX_FSEL_LO
        |=> st.fsel_lo == $past(dat_i[7:0]))
        else $error("function low write lost");

    fsel_pair_write_a: assert property (wr_any_s ##0 sel_i[1] && idx == `GPM_IDX_FSEL_LO
        |=> st.fsel_hi == $past(dat_i[15:8]))
        else $error("function high via word lost");

    fsel_hi_write_a: assert property (wr_any_s ##0 sel_i[0] && idx == `GPM_IDX_FSEL_HI
        |=> st.fsel_hi == $past(dat_i[7:0]))
        else $error("function high write lost");

    masked_write_a: assert property (wr_any_s ##0 !sel_i[0] && idx == `GPM_IDX_DATA
        |=> $stable(st.data))
        else $error("masked byte written");

    read_no_write_a: assert property (rd_any_s
        |=> $stable(st.data) && $stable(st.dir) && $stable(st.cfg_lo) && $stable(st.fsel_hi))
        else $error("read changed a register");

    ack_idle_a: assert property (!(cyc_i && stb_i)
        |=> !ack_o)
        else $error("ack without strobe");

    pull_down_a: assert property (st.dir[1] && {st.cfg_hi[1], st.cfg_lo[1]} == `GPM_IN_PD
        |=> pull_down_o[1] && !pull_up_o[1])
        else $error("pull-down not applied");

    hiz_input_a: assert property (st.dir[2] && st.cfg_hi[2] && st.cfg_lo[2]
        |=> !pull_up_o[2] && !pull_down_o[2])
        else $error("code 11 input not plain");

    output_no_pull_a: assert property (!st.dir[4]
        |=> !pull_up_o[4] && !pull_down_o[4])
        else $error("pull on an output pin");

    hiz_output_a: assert property (!st.dir[1] && !st.cfg_hi[1] && !st.cfg_lo[1]
        |=> !pin_oe_o[1])
        else $error("hiz output driven");

    pch_drive_a: assert property (!st.dir[2] && !st.fsel_hi[2] && !st.fsel_lo[2]
        && !st.cfg_hi[2] && st.cfg_lo[2]
        |=> pin_oe_o[2] == $past(st.data[2]) && pin_o[2])
        else $error("p-channel drive wrong");

    nch_drive_a: assert property (!st.dir[3] && !st.fsel_hi[3] && !st.fsel_lo[3]
        && st.cfg_hi[3] && !st.cfg_lo[3]
        |=> pin_oe_o[3] == !$past(st.data[3]) && !pin_o[3])
        else $error("n-channel drive wrong");

    pwm_channel_four_route_a: assert property (!st.dir[4] && st.fsel_hi[4] && !st.fsel_lo[4]
        && st.cfg_hi[4] && st.cfg_lo[4]
        |=> pin_oe_o[4] && pin_o[4] == $past(pwm_channel_four_i))
        else $error("pwm four not on pin 4");

    pwm_channel_five_route_a: assert property (!st.dir[5] && st.fsel_hi[5] && !st.fsel_lo[5]
        && st.cfg_hi[5] && st.cfg_lo[5]
        |=> pin_oe_o[5] && pin_o[5] == $past(pwm_channel_five_i))
        else $error("pwm five not on pin 5");

    prohibited_hiz_a: assert property (!st.dir[3] && st.fsel_lo[3] && !st.cfg_hi[3]
        |=> !pin_oe_o[3])
        else $error("prohibited code not held hiz");

    pin6_prohibited_a: assert property (!st.dir[6] && st.fsel_hi[6] && st.cfg_hi[6]
        |=> pin_oe_o[6] && !pin_o[6])
        else $error("pin 6 prohibited code not low");

    pin4_prohibited_a: assert property (!st.dir[4] && st.fsel_lo[4] && st.cfg_hi[4]
        |=> pin_oe_o[4] && !pin_o[4])
        else $error("pin 4 prohibited code not low");

    pin5_prohibited_a: assert property (!st.dir[5] && st.fsel_lo[5] && st.cfg_hi[5]
        |=> pin_oe_o[5] && !pin_o[5])
        else $error("pin 5 prohibited code not low");

    low_pin_prohibited_a: assert property (!st.dir[1] && st.fsel_hi[1] && st.cfg_hi[1]
        |=> pin_oe_o[1] && !pin_o[1])
        else $error("low pin alternate code not blocked");

    // direction wins over any function code, so an input never fights the board
    input_dir_wins_a: assert property (st.dir[6] && st.fsel_lo[6]
        |=> !pin_oe_o[6])
        else $error("input pin driven by function");

    reset_outputs_a: assert property ($rose(!rst_i)
        |-> !ack_o && dat_o == 32'h0000_0000 && pull_up_o == '0 && pull_down_o == '0
        && st.fsel_lo == 8'h00 && st.fsel_hi == 8'h00)
        else $error("outputs not idle after reset");
endmodule
`default_nettype wire

// ===== testbench/gpm_board.sv
// board-side model of the seven port pins
`timescale 1ns/1ns
`default_nettype none
module gpm_board
(
    input  wire logic       clk_i,
    input  wire logic [6:0] drv_i,
    input  wire logic [6:0] oe_i,
    input  wire logic [6:0] pu_i,
    input  wire logic [6:0] pd_i,
    input  wire logic [6:0] ext_en_i,
    input  wire logic [6:0] ext_v_i,
    output logic      [6:0] lvl_o
);
    logic [6:0] flt = 7'h2a;
    // a floating, unpulled wire never shows a steady level
    always @(posedge clk_i)
    begin
        flt <= ~flt;
    end
    assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_v_i)
        | (~oe_i & ~ext_en_i & (pu_i | (~pd_i & flt)));
endmodule
`default_nettype wire

// ===== testbench/seven_pin_gpio_port_mux_tb.sv
// self-checking bench of the seven-pin port
`timescale 1ns/1ns
`default_nettype none
`include "gpm_consts.svh"
module seven_pin_gpio_port_mux_tb import gpm_pkg::*;;
    logic        clk_i = 0;
    logic        rst_i = 1;
    logic        cyc = 0;
    logic        we = 0;
    logic [17:0] adr = 0;
    logic [3:0]  sel = 0;
    logic [31:0] wdat = 0;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        evt;
    logic [6:0]  lvl, pin_o, oe, pu, pd;
    logic [6:0]  ext_en = 0;
    logic [6:0]  ext_v = 0;
    logic [2:0]  src = 0;
    int          error_cnt = 0;
    int          cmp_count = 0;
    gpm_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .pin_i(lvl), .pin_o(pin_o),
        .pin_oe_o(oe), .pull_up_o(pu), .pull_down_o(pd), .low_speed_clock_i(src[2]),
        .pwm_channel_four_i(src[0]), .pwm_channel_five_i(src[1]), .pwm_external_event_input_o(evt));
    gpm_board board_u (.clk_i(clk_i), .drv_i(pin_o), .oe_i(oe), .pu_i(pu), .pd_i(pd),
        .ext_en_i(ext_en), .ext_v_i(ext_v), .lvl_o(lvl));
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic results();
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    // one classic cycle; cyc also serves as stb since both rise and fall together
    task automatic wb(input logic w, input logic [15:0] idx, input logic [3:0] s, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        wdat <= d;
        for (int n = 0; n < 20 && ack_o !== 1'b1; n++)
            wt(1);
        if (ack_o !== 1'b1)
        begin
            error_cnt++;
            results();
        end
        rdat = dat_o;
        @(posedge clk_i);
        cyc <= 0;
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [31:0] e, input string nm);
        wb(0, idx, 4'hf, 0);
        cmp(nm, e, rdat);
    endtask
    task automatic setx(input logic [6:0] en, input logic [6:0] v);
        @(posedge clk_i);
        ext_en <= en;
        ext_v <= v;
        wt(5);
    endtask
    // uniform drive code c, effective output value v on every pin
    task automatic chkp(input logic [1:0] c, input logic [6:0] v);
        logic [6:0] eo;
        wt(3);
        eo = c == 2'b11 ? 7'h7f : c == 2'b01 ? v : c == 2'b10 ? ~v : 7'h00;
        cmp("pin_oe_o", eo, oe);
        cmp("pin_o", eo & (c == 2'b11 ? v : {7{c == 2'b01}}), oe & pin_o);
    endtask
    task automatic s_reset();
        cmp("pin_oe_o", 0, oe);
        cmp("pulls", 0, {pu, pd});
        rdc(`GPM_IDX_DATA, 0, "data");
        rdc(`GPM_IDX_DIR, 0, "dir");
        rdc(`GPM_IDX_CFG_LO, 0, "cfg");
        rdc(`GPM_IDX_FSEL_LO, 0, "fsel");
        wb(1, 16'hf21e, 4'hf, 32'hffff);
        rdc(16'hf21e, 0, "unmapped");
    endtask
    task automatic s_drive();
        wb(1, `GPM_IDX_DATA, 4'h1, 32'hd5);
        rdc(`GPM_IDX_DATA, 32'h55, "data");
        for (int c = 0; c < 4; c++)
        begin
            wb(1, `GPM_IDX_CFG_LO, 4'h3, {16'h0, {8{c[1]}}, {8{c[0]}}});
            chkp(c[1:0], 7'h55);
        end
        cmp("wire", 7'h55, lvl);
        rdc(`GPM_IDX_CFG_LO, 32'hffff, "cfg_word");
        rdc(`GPM_IDX_CFG_HI, 32'hff, "cfg_hi");
    endtask
    task automatic s_input();
        wb(1, `GPM_IDX_DIR, 4'h1, 32'hff);
        rdc(`GPM_IDX_DIR, 32'h7f, "dir");
        setx(7'h7f, 7'h2a);
        cmp("pin_oe_o", 0, oe);
        rdc(`GPM_IDX_DATA, 32'h2a, "data_in");
        setx(7'h01, 7'h01);
        cmp("event", 1, evt);
        setx(7'h01, 7'h00);
        cmp("event", 0, evt);
        setx(7'h00, 7'h00);
        for (int c = 0; c < 4; c++)
        begin
            wb(1, `GPM_IDX_CFG_LO, 4'h3, {16'h0, {8{c[1]}}, {8{c[0]}}});
            wt(4);
            cmp("pull_up_o", c == 2 ? 7'h7f : 7'h00, pu);
            cmp("pull_down_o", c == 1 ? 7'h7f : 7'h00, pd);
            if (c == 1 || c == 2)
                rdc(`GPM_IDX_DATA, c == 2 ? 32'h7f : 32'h0, "data_pull");
        end
    endtask
    task automatic s_func();
        wb(1, `GPM_IDX_DIR, 4'h1, 0);
        wb(1, `GPM_IDX_CFG_LO, 4'h3, 32'hffff);
        wb(1, `GPM_IDX_FSEL_LO, 4'h3, 32'h3040);
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk_i);
            src <= k[2:0];
            wt(3);
            cmp("alt_out", {k[2:0], 4'h0}, {oe[6:4] & pin_o[6:4], 4'h0});
        end
        rdc(`GPM_IDX_FSEL_LO, 32'h3040, "fsel_word");
        wb(1, `GPM_IDX_FSEL_LO, 4'h3, 32'h4f3f);
        for (int c = 0; c < 4; c++)
        begin
            wb(1, `GPM_IDX_CFG_LO, 4'h3, {16'h0, {8{c[1]}}, {8{c[0]}}});
            chkp(c[1:0], 7'h00);
        end
        // analog use of the low pins wants high-impedance output
        wb(1, `GPM_IDX_CFG_LO, 4'h3, 0);
        chkp(2'b00, 7'h00);
    endtask
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        wt(1);
        s_reset();
        s_drive();
        s_input();
        s_func();
        results();
    end
endmodule
`default_nettype wire
